// ---- bench/spcr_host_model.sv ----
`timescale 1ns/10ps
module spcr_host_model (
  // Clock
  input  wire logic        mclk,
  // Register port
  output logic      [7:0]  reg_addr,
  output logic             reg_wr,
  output logic             reg_rd,
  output logic      [15:0] reg_wdata,
  input  wire logic [15:0] reg_rdata,
  input  wire logic        reg_rvalid
);
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 16'h0000;
  end

  // Strobes last one cycle; the host never expects a new setting before a reset
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge mclk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge mclk);
    reg_wr = 1'b0;
  endtask

  // A missing answer shows as a marker value the tests never expect
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(negedge mclk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge mclk);
    reg_rd = 1'b0;
    d = reg_rvalid ? reg_rdata : 16'hdead;
  endtask
endmodule

// ---- bench/tb_top.sv ----
`timescale 1ns/10ps
module tb_top;
  logic        mclk, rst, ce, reg_wr, reg_rd, reg_rvalid, nv_load, sr_err;
  logic        parity_enable_bit, odd_parity_select, two_stop_bits_select;
  logic        spi_cpol, spi_cpha, applied;
  logic [7:0]  reg_addr, cfg_rate, cfg_fmt, nv_mode, nv_spi, nv_rate;
  logic [7:0]  cfg_rate_code, sync_mode_code, sync_rate_code, i;
  logic [15:0] reg_wdata, reg_rdata, e;
  int          errors, n_tests;

  spcr_host_model u_spcr_host_model (.mclk(mclk), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

  spcr_regs u_spcr_regs (.mclk(mclk), .rst(rst), .ce(ce), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .cfg_bitrate_setting(cfg_rate), .cfg_format_setting(cfg_fmt),
    .nv_load(nv_load), .nv_mode(nv_mode), .nv_spi_fmt(nv_spi), .nv_sync_rate(nv_rate),
    .shift_register_chain_error(sr_err), .cfg_rate_code(cfg_rate_code),
    .parity_enable_bit(parity_enable_bit), .odd_parity_select(odd_parity_select),
    .two_stop_bits_select(two_stop_bits_select), .sync_mode_code(sync_mode_code),
    .spi_cpol(spi_cpol), .spi_cpha(spi_cpha), .sync_rate_code(sync_rate_code),
    .settings_applied(applied));

  always #5 mclk = ~mclk;

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [15:0] exp);
    logic [15:0] d;
    u_spcr_host_model.rd(a, d);
    chk(d, exp);
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    u_spcr_host_model.wr(a, d);
  endtask
  // Soft reset command, then room for the copy into the active side
  task automatic apply;
    wr(8'h01, 16'h0003);
    @(negedge mclk);
    chk({15'h0, applied}, 16'h0001);
    @(negedge mclk);
    chk({15'h0, applied}, 16'h0000);
    @(negedge mclk);
  endtask
  task automatic close_out;
    $display("Comparisons %0d, mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_defaults;
    rdc(8'h16, 16'h0001);
    rdc(8'h17, 16'h0001);
    rdc(8'h18, 16'h0004);
    rdc(8'h19, 16'h0004);
    rdc(8'h1a, 16'h0001);
    rdc(8'h14, 16'h0003);
    rdc(8'h15, 16'h0005);
    chk({13'h0, two_stop_bits_select, odd_parity_select, parity_enable_bit}, 16'h0005);
  endtask
  task automatic t_gate;
    wr(8'h16, 16'h0003);
    wr(8'h01, 16'h0002);
    rdc(8'h16, 16'h0003);
    rdc(8'h17, 16'h0001);
    apply();
    rdc(8'h17, 16'h0003);
  endtask
  task automatic t_spi_fmt;
    for (i = 8'h01; i <= 8'h04; i++) begin
      wr(8'h18, {8'h00, i});
      apply();
      rdc(8'h19, {8'h00, i});
      // Expected {cpol, cpha} for each format code
      e = (i == 8'h01) ? 16'h0000 : (i == 8'h02) ? 16'h0002 : (i == 8'h03) ? 16'h0001 : 16'h0003;
      chk({14'h0, spi_cpol, spi_cpha}, e);
    end
  endtask
  task automatic t_modes;
    wr(8'h18, 16'h0002);
    for (i = 8'h00; i <= 8'h04; i++) begin
      wr(8'h16, {8'h00, i});
      apply();
      e = (i == 8'h04) ? 16'h0001 : {8'h00, i};
      rdc(8'h17, e);
      chk({8'h00, sync_mode_code}, e);
      chk({14'h0, spi_cpol, spi_cpha}, (i == 8'h00 || i == 8'h03) ? 16'h0002 : 16'h0003);
      e = (i == 8'h00) ? 16'h0000 : (i == 8'h03) ? 16'h0002 : 16'h0004;
      rdc(8'h19, e);
    end
    wr(8'h16, 16'h0003);
    for (i = 8'h00; i <= 8'h04; i++) begin
      wr(8'h1a, {8'h00, i});
      apply();
      chk({8'h00, sync_rate_code}, (i == 8'h04) ? 16'h0001 : {8'h00, i});
      rdc(8'h19, (i == 8'h00) ? 16'h0000 : 16'h0002);
    end
  endtask
  task automatic t_error;
    wr(8'h16, 16'h0001);
    apply();
    sr_err = 1'b1;
    repeat (5) @(negedge mclk);
    rdc(8'h17, 16'h0004);
    wr(8'h16, 16'h0003);
    apply();
    rdc(8'h17, 16'h0003);
    sr_err = 1'b0;
  endtask
  task automatic t_fallback;
    cfg_rate = 8'h08;
    apply();
    rdc(8'h14, 16'h0007);
    rdc(8'h15, 16'h0000);
    cfg_rate = 8'h02;
    cfg_fmt = 8'h0a;
    apply();
    rdc(8'h14, 16'h0007);
    cfg_fmt = 8'h02;
    apply();
    rdc(8'h15, 16'h0002);
    chk({15'h0, odd_parity_select}, 16'h0000);
    chk({8'h00, cfg_rate_code}, 16'h0002);
  endtask
  task automatic t_readonly;
    wr(8'h14, 16'hffff);
    wr(8'h15, 16'hffff);
    wr(8'h17, 16'hffff);
    wr(8'h19, 16'hffff);
    wr(8'h30, 16'hffff);
    ce = 1'b0;
    wr(8'h16, 16'h0000);
    ce = 1'b1;
    rdc(8'h14, 16'h0002);
    rdc(8'h15, 16'h0002);
    rdc(8'h17, 16'h0003);
    rdc(8'h19, 16'h0002);
    rdc(8'h30, 16'h0000);
    rdc(8'h16, 16'h0003);
  endtask
  task automatic t_persist;
    nv_mode = 8'h02;
    nv_spi = 8'h01;
    nv_rate = 8'h03;
    nv_load = 1'b1;
    @(negedge mclk);
    nv_load = 1'b0;
    rdc(8'h16, 16'h0002);
    rdc(8'h18, 16'h0001);
    rdc(8'h1a, 16'h0003);
    rst = 1'b1;
    repeat (3) @(negedge mclk);
    rst = 1'b0;
    @(negedge mclk);
    chk({15'h0, applied}, 16'h0001);
    rdc(8'h16, 16'h0001);
    rdc(8'h18, 16'h0004);
    rdc(8'h1a, 16'h0001);
  endtask

  initial begin
    repeat (5000) @(posedge mclk);
    errors++;
    close_out();
  end

  initial begin
    mclk = 1'b0;
    rst = 1'b1;
    ce = 1'b1;
    nv_load = 1'b0;
    sr_err = 1'b0;
    cfg_rate = 8'h03;
    cfg_fmt = 8'h05;
    nv_mode = 8'h00;
    nv_spi = 8'h00;
    nv_rate = 8'h00;
    errors = 0;
    n_tests = 0;
    repeat (20) @(negedge mclk);
    rst = 1'b0;
    @(negedge mclk);
    chk({15'h0, applied}, 16'h0001);
    @(negedge mclk);
    t_defaults();
    t_gate();
    t_spi_fmt();
    t_modes();
    t_error();
    t_fallback();
    t_readonly();
    t_persist();
    close_out();
  end
endmodule

// ---- inc/spcr_consts.svh ----
`ifndef SPCR_CONSTS_SVH
`define SPCR_CONSTS_SVH

// Register offsets
`define SPCR_OFS_DEV_CTRL      8'h01
`define SPCR_OFS_CFG_BITRATE   8'h14
`define SPCR_OFS_CFG_FORMAT    8'h15
`define SPCR_OFS_MODE_SEL      8'h16
`define SPCR_OFS_MODE_STAT     8'h17
`define SPCR_OFS_SPI_FMT_SEL   8'h18
`define SPCR_OFS_SPI_FMT_STAT  8'h19
`define SPCR_OFS_SYNC_RATE_SEL 8'h1a

// Device control command that re-applies settings
`define SPCR_SOFT_RESET_CMD    16'h0003

// Configuration port bitrate codes
`define SPCR_CFG_RATE_MIN      8'h01
`define SPCR_CFG_RATE_MAX      8'h07
`define SPCR_CFG_RATE_FALLBACK 8'h07

// Format byte fields
`define SPCR_FMT_PEN_BIT       0
`define SPCR_FMT_ODD_BIT       1
`define SPCR_FMT_STOP_BIT      2
`define SPCR_FMT_USED_MASK     8'h07
`define SPCR_FMT_FALLBACK      8'h00

// Synchronous port mode codes
`define SPCR_MODE_OFF          8'h00
`define SPCR_MODE_AUTO         8'h01
`define SPCR_MODE_MANUAL       8'h02
`define SPCR_MODE_SPI_SLAVE    8'h03
`define SPCR_MODE_ERROR        8'h04
`define SPCR_MODE_DEFAULT      8'h01

// SPI clock format codes
`define SPCR_SPI_OFF           8'h00
`define SPCR_SPI_FMT_MIN       8'h01
`define SPCR_SPI_FMT_MAX       8'h04
`define SPCR_SPI_FMT_MASTER    8'h04
`define SPCR_SPI_FMT_DEFAULT   8'h04
// Odd format codes idle the clock low; codes from 3 up sample on the lagging edge
`define SPCR_SPI_IDLE_LOW_BIT  0
`define SPCR_SPI_FMT_LAG_MIN   8'h03

// Synchronous bitrate codes
`define SPCR_SYNC_RATE_OFF     8'h00
`define SPCR_SYNC_RATE_MAX     8'h03
`define SPCR_SYNC_RATE_DEFAULT 8'h01

`endif

// ---- inc/spcr_pkg.sv ----
package spcr_pkg;
  typedef logic [7:0]  spcr_byte_t;
  typedef logic [15:0] spcr_word_t;
endpackage

// ---- src/spcr_regs.sv ----
`timescale 1ns/10ps
`include "spcr_consts.svh"

module spcr_regs (
  // Clock and control
  input  wire logic               mclk,
  input  wire logic               rst,
  input  wire logic               ce,
  // Register port
  input  wire logic [7:0]         reg_addr,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  input  wire logic [15:0]        reg_wdata,
  output logic      [15:0]        reg_rdata,
  output logic                    reg_rvalid,
  // Config port settings held elsewhere
  input  wire spcr_pkg::spcr_byte_t cfg_bitrate_setting,
  input  wire spcr_pkg::spcr_byte_t cfg_format_setting,
  // Nonvolatile restore of the persistent bytes
  input  wire logic               nv_load,
  input  wire spcr_pkg::spcr_byte_t nv_mode,
  input  wire spcr_pkg::spcr_byte_t nv_spi_fmt,
  input  wire spcr_pkg::spcr_byte_t nv_sync_rate,
  // Shift-register master status
  input  wire logic               shift_register_chain_error,
  // Active settings
  output spcr_pkg::spcr_byte_t    cfg_rate_code,
  output logic                    parity_enable_bit,
  output logic                    odd_parity_select,
  output logic                    two_stop_bits_select,
  output spcr_pkg::spcr_byte_t    sync_mode_code,
  output logic                    spi_cpol,
  output logic                    spi_cpha,
  output spcr_pkg::spcr_byte_t    sync_rate_code,
  output logic                    settings_applied
);

  // ----------------------------------------------------------------
  // Setting and active state
  // ----------------------------------------------------------------
  spcr_pkg::spcr_byte_t mode_sel_ff, nxt_mode_sel;
  spcr_pkg::spcr_byte_t spi_sel_ff, nxt_spi_sel;
  spcr_pkg::spcr_byte_t rate_sel_ff, nxt_rate_sel;
  spcr_pkg::spcr_byte_t cfg_rate_ff, nxt_cfg_rate;
  spcr_pkg::spcr_byte_t cfg_fmt_ff, nxt_cfg_fmt;
  spcr_pkg::spcr_byte_t mode_act_ff, nxt_mode_act;
  spcr_pkg::spcr_byte_t spi_act_ff, nxt_spi_act;
  spcr_pkg::spcr_byte_t rate_act_ff, nxt_rate_act;
  spcr_pkg::spcr_byte_t mode_stat_ff, nxt_mode_stat;
  logic                 pend_ff, nxt_pend;
  logic                 applied_ff, nxt_applied;
  logic                 err_meta_ff, err_sync_ff;
  logic [15:0]          rdata_ff, nxt_rdata;
  logic                 rvalid_ff, nxt_rvalid;
  logic                 odd_ff, nxt_odd;
  logic                 cpol_ff, nxt_cpol;
  logic                 cpha_ff, nxt_cpha;

  logic                 soft_rst_wr;
  logic                 cfg_bad;
  spcr_pkg::spcr_word_t spi_stat;

  function automatic logic is_master(input spcr_pkg::spcr_byte_t m);
    is_master = (m == `SPCR_MODE_AUTO) || (m == `SPCR_MODE_MANUAL);
  endfunction

  assign soft_rst_wr = reg_wr && (reg_addr == `SPCR_OFS_DEV_CTRL)
                       && (reg_wdata == `SPCR_SOFT_RESET_CMD);
  assign cfg_bad = (cfg_bitrate_setting < `SPCR_CFG_RATE_MIN)
                   || (cfg_bitrate_setting > `SPCR_CFG_RATE_MAX)
                   || ((cfg_format_setting & ~`SPCR_FMT_USED_MASK) != 8'h00);

  // Port off when mode or rate is off; master forces its fixed format
  always_comb begin
    if (mode_act_ff == `SPCR_MODE_OFF || rate_act_ff == `SPCR_SYNC_RATE_OFF) begin
      spi_stat = {8'h00, `SPCR_SPI_OFF};
    end else if (is_master(mode_act_ff)) begin
      spi_stat = {8'h00, `SPCR_SPI_FMT_MASTER};
    end else begin
      spi_stat = {8'h00, spi_act_ff};
    end
  end

  always_comb begin
    nxt_mode_sel = mode_sel_ff;
    nxt_spi_sel  = spi_sel_ff;
    nxt_rate_sel = rate_sel_ff;
    nxt_cfg_rate = cfg_rate_ff;
    nxt_cfg_fmt  = cfg_fmt_ff;
    nxt_mode_act = mode_act_ff;
    nxt_spi_act  = spi_act_ff;
    nxt_rate_act = rate_act_ff;
    nxt_pend     = pend_ff;
    nxt_applied  = 1'b0;
    // Restore from storage takes precedence over a host write
    if (nv_load) begin
      nxt_mode_sel = nv_mode;
      nxt_spi_sel  = nv_spi_fmt;
      nxt_rate_sel = nv_sync_rate;
    end else if (reg_wr) begin
      // Status offsets have no write path
      unique case (reg_addr)
        `SPCR_OFS_MODE_SEL:      nxt_mode_sel = reg_wdata[7:0];
        `SPCR_OFS_SPI_FMT_SEL:   nxt_spi_sel  = reg_wdata[7:0];
        `SPCR_OFS_SYNC_RATE_SEL: nxt_rate_sel = reg_wdata[7:0];
        default: ;
      endcase
    end
    if (soft_rst_wr) begin
      nxt_pend = 1'b1;
    end
    // Settings are copied to the active side one cycle after any reset
    if (pend_ff) begin
      nxt_pend    = soft_rst_wr;
      nxt_applied = 1'b1;
      if (cfg_bad) begin
        nxt_cfg_rate = `SPCR_CFG_RATE_FALLBACK;
        nxt_cfg_fmt  = `SPCR_FMT_FALLBACK;
      end else begin
        nxt_cfg_rate = cfg_bitrate_setting;
        nxt_cfg_fmt  = cfg_format_setting & `SPCR_FMT_USED_MASK;
      end
      // Out-of-range persistent bytes revert to defaults, never stall the port
      nxt_mode_act = (mode_sel_ff > `SPCR_MODE_SPI_SLAVE) ?
                     `SPCR_MODE_DEFAULT : mode_sel_ff;
      nxt_spi_act  = (spi_sel_ff < `SPCR_SPI_FMT_MIN || spi_sel_ff > `SPCR_SPI_FMT_MAX) ?
                     `SPCR_SPI_FMT_DEFAULT : spi_sel_ff;
      nxt_rate_act = (rate_sel_ff > `SPCR_SYNC_RATE_MAX) ?
                     `SPCR_SYNC_RATE_DEFAULT : rate_sel_ff;
    end
    nxt_mode_stat = (is_master(mode_act_ff) && err_sync_ff) ?
                    `SPCR_MODE_ERROR : mode_act_ff;
    // Line-side format flops follow the next active values, so they never lag
    // the active registers by a cycle
    nxt_odd  = nxt_cfg_fmt[`SPCR_FMT_ODD_BIT] & nxt_cfg_fmt[`SPCR_FMT_PEN_BIT];
    nxt_cpol = ~nxt_spi_act[`SPCR_SPI_IDLE_LOW_BIT] | is_master(nxt_mode_act);
    nxt_cpha = (nxt_spi_act >= `SPCR_SPI_FMT_LAG_MIN) | is_master(nxt_mode_act);
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      mode_sel_ff  <= `SPCR_MODE_DEFAULT;
      spi_sel_ff   <= `SPCR_SPI_FMT_DEFAULT;
      rate_sel_ff  <= `SPCR_SYNC_RATE_DEFAULT;
      cfg_rate_ff  <= `SPCR_CFG_RATE_FALLBACK;
      cfg_fmt_ff   <= `SPCR_FMT_FALLBACK;
      mode_act_ff  <= `SPCR_MODE_DEFAULT;
      spi_act_ff   <= `SPCR_SPI_FMT_DEFAULT;
      rate_act_ff  <= `SPCR_SYNC_RATE_DEFAULT;
      mode_stat_ff <= `SPCR_MODE_DEFAULT;
      pend_ff      <= 1'b1;
      applied_ff   <= 1'b0;
      odd_ff       <= 1'b0;
      // Mode 1 after reset is a master mode, so the line format starts at 4
      cpol_ff      <= 1'b1;
      cpha_ff      <= 1'b1;
    end else if (ce) begin
      mode_sel_ff  <= nxt_mode_sel;
      spi_sel_ff   <= nxt_spi_sel;
      rate_sel_ff  <= nxt_rate_sel;
      cfg_rate_ff  <= nxt_cfg_rate;
      cfg_fmt_ff   <= nxt_cfg_fmt;
      mode_act_ff  <= nxt_mode_act;
      spi_act_ff   <= nxt_spi_act;
      rate_act_ff  <= nxt_rate_act;
      mode_stat_ff <= nxt_mode_stat;
      pend_ff      <= nxt_pend;
      applied_ff   <= nxt_applied;
      odd_ff       <= nxt_odd;
      cpol_ff      <= nxt_cpol;
      cpha_ff      <= nxt_cpha;
    end
  end

  // ----------------------------------------------------------------
  // Error input synchroniser
  // ----------------------------------------------------------------
  // Error comes from the chain pins, so it is treated as asynchronous
  always_ff @(posedge mclk) begin
    if (rst) begin
      err_meta_ff <= 1'b0;
      err_sync_ff <= 1'b0;
    end else if (ce) begin
      err_meta_ff <= shift_register_chain_error;
      err_sync_ff <= err_meta_ff;
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  always_comb begin
    nxt_rvalid = reg_rd;
    nxt_rdata  = 16'h0000;
    if (reg_rd) begin
      unique case (reg_addr)
        `SPCR_OFS_CFG_BITRATE:   nxt_rdata = {8'h00, cfg_rate_ff};
        `SPCR_OFS_CFG_FORMAT:    nxt_rdata = {8'h00, cfg_fmt_ff};
        `SPCR_OFS_MODE_SEL:      nxt_rdata = {8'h00, mode_sel_ff};
        `SPCR_OFS_MODE_STAT:     nxt_rdata = {8'h00, mode_stat_ff};
        `SPCR_OFS_SPI_FMT_SEL:   nxt_rdata = {8'h00, spi_sel_ff};
        `SPCR_OFS_SPI_FMT_STAT:  nxt_rdata = spi_stat;
        `SPCR_OFS_SYNC_RATE_SEL: nxt_rdata = {8'h00, rate_sel_ff};
        default:                 nxt_rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      rdata_ff  <= 16'h0000;
      rvalid_ff <= 1'b0;
    end else if (ce) begin
      rdata_ff  <= nxt_rdata;
      rvalid_ff <= nxt_rvalid;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign reg_rdata            = rdata_ff;
  assign reg_rvalid           = rvalid_ff;
  assign cfg_rate_code        = cfg_rate_ff;
  assign parity_enable_bit    = cfg_fmt_ff[`SPCR_FMT_PEN_BIT];
  // Datapath sees odd only when parity is on
  assign odd_parity_select    = odd_ff;
  assign two_stop_bits_select = cfg_fmt_ff[`SPCR_FMT_STOP_BIT];
  assign sync_mode_code       = mode_stat_ff;
  assign spi_cpol             = cpol_ff;
  assign spi_cpha             = cpha_ff;
  assign sync_rate_code       = rate_act_ff;
  assign settings_applied     = applied_ff;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_CFG_RATE_RANGE: assert property (@(posedge mclk) disable iff (rst)
    cfg_rate_ff >= `SPCR_CFG_RATE_MIN && cfg_rate_ff <= `SPCR_CFG_RATE_MAX)
    else $error("config bitrate code out of range");
  AST_APPLY_ONLY_ON_RESET: assert property (@(posedge mclk) disable iff (rst)
    ce && !pend_ff |=> $stable(mode_act_ff) && $stable(rate_act_ff))
    else $error("active setting changed without reset");
  AST_SOFT_RESET_APPLIES: assert property (@(posedge mclk) disable iff (rst)
    ce && soft_rst_wr ##1 ce[*2] |-> applied_ff)
    else $error("soft reset did not apply settings");
  AST_ODD_IGNORED: assert property (@(posedge mclk) disable iff (rst)
    !parity_enable_bit |-> !odd_parity_select)
    else $error("odd parity active with parity off");
  AST_MODE_WRITE: assert property (@(posedge mclk) disable iff (rst)
    ce && !nv_load && reg_wr && reg_addr == `SPCR_OFS_MODE_SEL
    |=> mode_sel_ff == $past(reg_wdata[7:0]))
    else $error("mode select write lost");
  AST_ERROR_STATUS: assert property (@(posedge mclk) disable iff (rst)
    ce && is_master(mode_act_ff) && err_sync_ff |=> mode_stat_ff == `SPCR_MODE_ERROR)
    else $error("error status not reported");
  AST_MASTER_FORMAT: assert property (@(posedge mclk) disable iff (rst)
    is_master(mode_act_ff) |-> spi_cpol && spi_cpha)
    else $error("master not in format 4");
  AST_SPI_OFF: assert property (@(posedge mclk) disable iff (rst)
    rate_act_ff == `SPCR_SYNC_RATE_OFF |-> spi_stat == 16'h0000)
    else $error("spi status not zero when off");
  AST_FALLBACK: assert property (@(posedge mclk) disable iff (rst)
    ce && pend_ff && cfg_bad |=> cfg_rate_ff == `SPCR_CFG_RATE_FALLBACK && cfg_fmt_ff == 8'h00)
    else $error("invalid config did not fall back");
  AST_FMT_UPPER_ZERO: assert property (@(posedge mclk) disable iff (rst)
    (cfg_fmt_ff & ~`SPCR_FMT_USED_MASK) == 8'h00)
    else $error("format upper bits not zero");
  AST_MODE_STAT_FOLLOWS: assert property (@(posedge mclk) disable iff (rst)
    ce && !err_sync_ff |=> mode_stat_ff == $past(mode_act_ff))
    else $error("mode status does not follow active mode");
  AST_SLAVE_FMT_ONE: assert property (@(posedge mclk) disable iff (rst)
    mode_act_ff == `SPCR_MODE_SPI_SLAVE && spi_act_ff == `SPCR_SPI_FMT_MIN
    |-> !spi_cpol && !spi_cpha)
    else $error("slave format 1 not idle low on leading edge");

  COV_SOFT_RESET: cover property (@(posedge mclk) disable iff (rst) ce && soft_rst_wr);
  COV_SPI_SLAVE: cover property (@(posedge mclk) disable iff (rst)
    mode_act_ff == `SPCR_MODE_SPI_SLAVE);
  COV_MASTER_ERR: cover property (@(posedge mclk) disable iff (rst)
    mode_stat_ff == `SPCR_MODE_ERROR);
  COV_FALLBACK: cover property (@(posedge mclk) disable iff (rst) ce && pend_ff && cfg_bad);
  COV_SYNC_OFF: cover property (@(posedge mclk) disable iff (rst)
    rate_act_ff == `SPCR_SYNC_RATE_OFF);

endmodule
